// ### pll_cfg_pkg.sv
// Constants and types for the clock conditioning configuration shifter
package pll_cfg_pkg;

  localparam int CONFIG_WIDTH = 81;
  localparam int COUNT_WIDTH = 7;
  localparam logic [COUNT_WIDTH-1:0] FRAME_BITS = 7'h51;

  // Bit positions of selected fields in the raw configuration vector
  localparam int RESET_ENABLE_BIT = 80;
  localparam int OUT_A_DYN_BIT = 77;
  localparam int OSC_RANGE_LSB = 74;
  localparam int OUT_A_STATIC_BIT = 71;
  localparam int OUT_C_DELAY_LSB = 66;
  localparam int GLOBAL_A_DELAY_LSB = 46;
  localparam int EXTRA_DELAY_BIT = 45;
  localparam int FB_DELAY_LSB = 40;
  localparam int FB_SOURCE_LSB = 38;
  localparam int OUT_C_ROUTE_LSB = 35;
  localparam int OUT_A_DIV_LSB = 14;
  localparam int FB_DIV_LSB = 7;
  localparam int IN_DIV_LSB = 0;

  // Register port map
  localparam int REG_ADDR_WIDTH = 4;
  localparam logic [REG_ADDR_WIDTH-1:0] CTRL_ADDR = 4'h0;
  localparam logic [REG_ADDR_WIDTH-1:0] STATUS_ADDR = 4'h4;
  localparam int CTRL_DYN_BIT = 0;
  localparam int STATUS_PENDING_BIT = 8;
  localparam int STATUS_FULL_BIT = 9;

  localparam logic [CONFIG_WIDTH-1:0] CONFIG_RESET = 81'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0;

  typedef struct packed {
    logic reset_enable;
    logic out_c_dynamic_select;
    logic out_b_dynamic_select;
    logic out_a_dynamic_select;
    logic [2:0] oscillator_range_select;
    logic out_c_static_select;
    logic out_b_static_select;
    logic out_a_static_select;
    logic [4:0] out_c_delay;
    logic [4:0] out_b_delay;
    logic [4:0] global_c_delay;
    logic [4:0] global_b_delay;
    logic [4:0] global_a_delay;
    logic extra_delay_select;
    logic [4:0] feedback_delay;
    logic [1:0] feedback_source_select;
    logic [2:0] out_c_route_select;
    logic [2:0] out_b_route_select;
    logic [2:0] out_a_route_select;
    logic [4:0] out_c_divider;
    logic [4:0] out_b_divider;
    logic [4:0] out_a_divider;
    logic [6:0] feedback_divider;
    logic [6:0] input_divider;
  } ccc_config_type;

  typedef struct packed {
    logic [REG_ADDR_WIDTH-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

endpackage

// ### pll_dynamic_config_shifter.sv
// Dynamic configuration shift register and active image for the clock conditioning block
//
// Operation
// (R1) Config from shifted register or static switches
// (R2) All 81 bits fully set block behaviour
// (R3) Decode reset enable, selects, oscillator range
// (R4) Decode delay fields and feedback source
// (R5) Decode route selects and divider fields
// (R6) Shift register reachable from fabric serial stream
// (R7) Reload at run time, no reprogramming
// (R8) Outside logic supplies data and controls shifting
// (R9) Tile gives two-way JTAG access always
// (R10) Shift 81 bits then pulse update
// (R11) Active image changes only on update
`timescale 1ns/10ps
module pll_dynamic_config_shifter (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic shift_en,
  input wire logic shift_data_in,
  input wire logic update,
  output logic shift_data_out,
  input wire logic [pll_cfg_pkg::CONFIG_WIDTH-1:0] static_config,
  input wire pll_cfg_pkg::reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  output pll_cfg_pkg::ccc_config_type ccc_config
);

  logic [pll_cfg_pkg::CONFIG_WIDTH-1:0] shadow_q;
  logic [pll_cfg_pkg::CONFIG_WIDTH-1:0] active_q;
  logic [pll_cfg_pkg::CONFIG_WIDTH-1:0] selected_d;
  logic [pll_cfg_pkg::CONFIG_WIDTH-1:0] config_q;
  logic [pll_cfg_pkg::COUNT_WIDTH-1:0] count_q;
  logic pending_q;
  logic use_dynamic_q;
  logic [31:0] status_word;

  // (R6) Serial shift path
  // First bit shifted ends at the top of the vector
  always_ff @(posedge clk) begin
    if (srst) begin
      shadow_q <= pll_cfg_pkg::CONFIG_RESET;
    end else if (ce && shift_en) begin
      shadow_q <= {shadow_q[pll_cfg_pkg::CONFIG_WIDTH-2:0], shift_data_in};
    end
  end

  // (R9) Return path always driven
  // Gives the tile's readback whether or not a shift is running
  assign shift_data_out = shadow_q[pll_cfg_pkg::CONFIG_WIDTH-1];

  // (R11) Update-only transfer
  // (R8) Relies on outside update
  always_ff @(posedge clk) begin
    if (srst) begin
      active_q <= pll_cfg_pkg::CONFIG_RESET;
    end else if (ce && update) begin
      active_q <= shadow_q;
    end
  end

  // (R10) Frame bit counter
  // Saturates so an overlong stream still reads as a full frame
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= '0;
    end else if (ce) begin
      if (update) begin
        count_q <= '0;
      end else if (shift_en && count_q != pll_cfg_pkg::FRAME_BITS) begin
        count_q <= count_q + 7'h01;
      end
    end
  end

  // Pending means shifted data not yet transferred; a shift in the
  // update cycle moves a fresh bit after the copy, so set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      pending_q <= 1'b0;
    end else if (ce) begin
      if (shift_en) begin
        pending_q <= 1'b1;
      end else if (update) begin
        pending_q <= 1'b0;
      end
    end
  end

  // (R7) Run-time mode control
  always_ff @(posedge clk) begin
    if (srst) begin
      use_dynamic_q <= 1'b0;
    end else if (ce && reg_req.wr && reg_req.addr == pll_cfg_pkg::CTRL_ADDR) begin
      use_dynamic_q <= reg_req.wdata[pll_cfg_pkg::CTRL_DYN_BIT];
    end
  end

  always_comb begin
    status_word = '0;
    status_word[pll_cfg_pkg::COUNT_WIDTH-1:0] = count_q;
    status_word[pll_cfg_pkg::STATUS_PENDING_BIT] = pending_q;
    status_word[pll_cfg_pkg::STATUS_FULL_BIT] = (count_q == pll_cfg_pkg::FRAME_BITS);
  end

  // Unmapped addresses read zero; data stand only the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= pll_cfg_pkg::RDATA_RESET;
    end else if (ce) begin
      if (reg_req.rd && reg_req.addr == pll_cfg_pkg::CTRL_ADDR) begin
        reg_rdata <= {31'h0, use_dynamic_q};
      end else if (reg_req.rd && reg_req.addr == pll_cfg_pkg::STATUS_ADDR) begin
        reg_rdata <= status_word;
      end else begin
        reg_rdata <= pll_cfg_pkg::RDATA_RESET;
      end
    end
  end

  // (R1) Source select
  assign selected_d = use_dynamic_q ? active_q : static_config;

  // (R2) Whole vector drives block
  // Registered so a source switch never glitches the clock settings
  always_ff @(posedge clk) begin
    if (srst) begin
      config_q <= pll_cfg_pkg::CONFIG_RESET;
    end else if (ce) begin
      config_q <= selected_d;
    end
  end

  // (R3) (R4) (R5) Field decode
  assign ccc_config = pll_cfg_pkg::ccc_config_type'(config_q);

  // (R11) Active image hold
  property p_active_hold;
    @(posedge clk) disable iff (srst)
      !(ce && update) |=> $stable(active_q);
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("active image moved without update"); // R11

  property p_update_copy;
    @(posedge clk) disable iff (srst)
      ce && update |=> active_q == $past(shadow_q);
  endproperty
  a_update_copy: assert property (p_update_copy) else $error("update did not copy shadow"); // R10

  property p_shift_step;
    @(posedge clk) disable iff (srst)
      ce && shift_en |=> shadow_q[0] == $past(shift_data_in)
        && shift_data_out == $past(shadow_q[pll_cfg_pkg::CONFIG_WIDTH-2]);
  endproperty
  a_shift_step: assert property (p_shift_step) else $error("shift step wrong"); // R6

  property p_source_select;
    @(posedge clk) disable iff (srst)
      ce ##1 !srst |-> config_q == ($past(use_dynamic_q) ? $past(active_q) : $past(static_config));
  endproperty
  a_source_select: assert property (p_source_select) else $error("wrong config source"); // R1

  property p_ctrl_write;
    @(posedge clk) disable iff (srst)
      ce && reg_req.wr && reg_req.addr == pll_cfg_pkg::CTRL_ADDR
        |=> use_dynamic_q == $past(reg_req.wdata[pll_cfg_pkg::CTRL_DYN_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("mode write lost"); // R7

  property p_decode_ctrl;
    @(posedge clk) disable iff (srst)
      ccc_config.reset_enable == config_q[pll_cfg_pkg::RESET_ENABLE_BIT]
        && ccc_config.out_a_dynamic_select == config_q[pll_cfg_pkg::OUT_A_DYN_BIT]
        && ccc_config.oscillator_range_select
          == config_q[pll_cfg_pkg::OSC_RANGE_LSB +: 3]
        && ccc_config.out_a_static_select == config_q[pll_cfg_pkg::OUT_A_STATIC_BIT];
  endproperty
  a_decode_ctrl: assert property (p_decode_ctrl) else $error("control field decode"); // R3

  property p_decode_delay;
    @(posedge clk) disable iff (srst)
      ccc_config.out_c_delay == config_q[pll_cfg_pkg::OUT_C_DELAY_LSB +: 5]
        && ccc_config.global_a_delay == config_q[pll_cfg_pkg::GLOBAL_A_DELAY_LSB +: 5]
        && ccc_config.extra_delay_select == config_q[pll_cfg_pkg::EXTRA_DELAY_BIT]
        && ccc_config.feedback_delay == config_q[pll_cfg_pkg::FB_DELAY_LSB +: 5]
        && ccc_config.feedback_source_select == config_q[pll_cfg_pkg::FB_SOURCE_LSB +: 2];
  endproperty
  a_decode_delay: assert property (p_decode_delay) else $error("delay field decode"); // R4

  property p_decode_div;
    @(posedge clk) disable iff (srst)
      ccc_config.out_c_route_select == config_q[pll_cfg_pkg::OUT_C_ROUTE_LSB +: 3]
        && ccc_config.out_a_divider == config_q[pll_cfg_pkg::OUT_A_DIV_LSB +: 5]
        && ccc_config.feedback_divider == config_q[pll_cfg_pkg::FB_DIV_LSB +: 7]
        && ccc_config.input_divider == config_q[pll_cfg_pkg::IN_DIV_LSB +: 7];
  endproperty
  a_decode_div: assert property (p_decode_div) else $error("divider field decode"); // R5

  property p_count_step;
    @(posedge clk) disable iff (srst)
      ce && shift_en && !update && count_q != pll_cfg_pkg::FRAME_BITS
        |=> count_q == $past(count_q) + 7'h01 && pending_q;
  endproperty
  a_count_step: assert property (p_count_step) else $error("bit count wrong"); // R10

  property p_static_path;
    @(posedge clk) disable iff (srst)
      ce && !use_dynamic_q |=> config_q == $past(static_config);
  endproperty
  a_static_path: assert property (p_static_path) else $error("static path broken"); // R2

  // (R11) Pending clears on update
  property p_pending_clear;
    @(posedge clk) disable iff (srst)
      ce && update && !shift_en |=> !pending_q && count_q == '0;
  endproperty
  a_pending_clear: assert property (p_pending_clear) else $error("pending not cleared"); // R11

  // (R7) Clock enable freezes state
  // Lets the fabric stall the loader without losing a half-shifted frame
  property p_freeze;
    @(posedge clk) disable iff (srst)
      !ce |=> $stable(shadow_q) && $stable(active_q) && $stable(count_q)
        && $stable(use_dynamic_q) && $stable(reg_rdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low"); // R7

  // (R2) Read data stand one cycle
  property p_read_idle;
    @(posedge clk) disable iff (srst)
      ce && !reg_req.rd |=> reg_rdata == pll_cfg_pkg::RDATA_RESET;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data stood too long"); // R2

endmodule // pll_dynamic_config_shifter

// ### cfg_stream_model.sv
// Fabric controller model that streams one configuration frame
`timescale 1ns/10ps
module cfg_stream_model (
  input wire logic clk,
  input wire logic start,
  input wire logic slow,
  input wire logic [80:0] frame,
  output logic shift_en,
  output logic shift_data_in,
  output logic update,
  output logic busy
);
  logic [6:0] count_q;
  logic gap_q;
  initial begin
    {shift_en, shift_data_in, update, busy, count_q, gap_q} = '0;
  end
  // Serial frame, then one update pulse
  always @(posedge clk) begin
    gap_q <= slow & ~gap_q;
    update <= 1'b0;
    shift_en <= 1'b0;
    // Idle data line shows inverse, so a stale bit never passes as good
    shift_data_in <= ~shift_data_in;
    if (start && !busy) begin
      busy <= 1'b1;
      count_q <= 7'h0;
    end else if (busy && count_q < 7'h51) begin
      if (!gap_q) begin
        shift_en <= 1'b1;
        shift_data_in <= frame[7'h50 - count_q];
        count_q <= count_q + 7'h1;
      end
    end else if (busy && count_q == 7'h51) begin
      update <= 1'b1;
      count_q <= 7'h52;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule // cfg_stream_model

// ### tb_top.sv
// Self-checking bench for the configuration shifter
`timescale 1ns/10ps
`define CHECK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t value mismatch", $time); end end
module tb_top;
  logic clk, srst, ce, start, slow, shift_en, sdi, update, busy, sdo;
  logic [80:0] frame, static_cfg;
  logic [31:0] rdata, rd_val;
  pll_cfg_pkg::reg_req_type req;
  pll_cfg_pkg::ccc_config_type cfg;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [80:0] rows [3] = '{81'h1_5555_aaaa_0f0f_f0f0_3c3c, 81'h0_ffff_0000_1234_5678_9abc,
    81'h1_fedc_ba98_7654_3210_0001};
  initial begin
    {clk, ce, start, slow} = 4'b0100;
    srst = 1'b1;
    frame = '0;
    static_cfg = 81'h0_a5a5_5a5a_c3c3_3c3c_7e7e;
    req = '0;
  end
  always #5 clk = ~clk;
  pll_dynamic_config_shifter uut (.clk(clk), .srst(srst), .ce(ce), .shift_en(shift_en),
    .shift_data_in(sdi), .update(update), .shift_data_out(sdo), .static_config(static_cfg),
    .reg_req(req), .reg_rdata(rdata), .ccc_config(cfg));
  cfg_stream_model ctl (.clk(clk), .start(start), .slow(slow), .frame(frame),
    .shift_en(shift_en), .shift_data_in(sdi), .update(update), .busy(busy));
  task end_of_test;
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, generous against the few frames sent
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test;
    end
  end
  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task reg_rd(input logic [3:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 rd_val = rdata;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHECK(cfg, static_cfg) // static settings after reset
    reg_wr(pll_cfg_pkg::CTRL_ADDR, 32'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      frame <= rows[i];
      slow <= i[0];
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (37) @(posedge clk);
      reg_rd(pll_cfg_pkg::STATUS_ADDR);
      `CHECK(rd_val[9:8], 2'b01) // pending, frame not yet full
      @(posedge clk);
      #1;
      `CHECK(cfg, (i == 0) ? 81'h0 : rows[i-1]) // image held while shifting
      for (int w = 0; w < 300 && busy === 1'b1; w++) @(posedge clk);
      repeat (3) @(posedge clk);
      #1;
      `CHECK(cfg, rows[i]) // whole vector loaded at run time
      `CHECK(sdo, rows[i][80]) // first bit reaches the far end
      `CHECK({cfg.reset_enable, cfg.out_a_dynamic_select}, {rows[i][80], rows[i][77]})
      `CHECK(cfg.oscillator_range_select, rows[i][76:74])
      `CHECK(cfg.out_a_static_select, rows[i][71])
      `CHECK({cfg.out_c_delay, cfg.global_a_delay}, {rows[i][70:66], rows[i][50:46]})
      `CHECK({cfg.feedback_delay, cfg.feedback_source_select}, rows[i][44:38])
      `CHECK({cfg.out_c_route_select, cfg.out_a_divider}, {rows[i][37:35], rows[i][18:14]})
      `CHECK({cfg.feedback_divider, cfg.input_divider}, rows[i][13:0])
    end
    // Count and pending clear once the frame is taken
    reg_rd(pll_cfg_pkg::STATUS_ADDR);
    `CHECK(rd_val, 32'h0) // status idle after update
    reg_rd(4'h8);
    `CHECK(rd_val, 32'h0) // unmapped place reads zero
    // Writes with the enable low must be ignored
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(pll_cfg_pkg::CTRL_ADDR, 32'h0);
    ce <= 1'b1;
    reg_rd(pll_cfg_pkg::CTRL_ADDR);
    `CHECK(rd_val, 32'h1) // dynamic mode kept through frozen write
    // Mid-run reset drops back to static settings
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHECK(cfg, static_cfg) // dynamic mode cleared by reset
    reg_rd(pll_cfg_pkg::CTRL_ADDR);
    `CHECK(rd_val, 32'h0) // mode register back to static
    end_of_test;
  end
endmodule // tb_top
